// >>> logic/trim_status_defs.vh
`ifndef TRIM_STATUS_DEFS_VH
`define TRIM_STATUS_DEFS_VH
// Number of constant-current sink channels.
`define CHAN_COUNT 16
// Width of one channel trim code.
`define TRIM_CODE_W 7
// Largest trim code, giving full-scale current.
`define TRIM_CODE_MAX 7'h7f
// Length of the trim shift register and the trim latch.
`define TRIM_CHAIN_W 112
// Length of the grayscale shift register.
`define GS_CHAIN_W 192
// Number of status bits overwritten at the top of the grayscale chain.
`define STATUS_W 17
// Grayscale clock rising edge on which open-LED results are saved.
`define OPEN_SAVE_EDGE 33
// Width of the grayscale edge counter in a display period.
`define GS_EDGE_CNT_W 12
// Register map offsets.
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STAT 12'h008
`define REG_IRQ_MASK 12'h00c
`define REG_TRIM_BASE 12'h040
// Interrupt status bit positions.
`define IRQ_TRIM_LATCH 0
`define IRQ_STATUS_LOAD 1
`define IRQ_OVERTEMP 2
`define IRQ_W 3
// Width of the current fraction output per channel.
`define CURRENT_W 16
`endif

// >>> logic/edge_sync.v
`timescale 1ns/100ps
`default_nettype none
// Three-stage synchroniser with rise and fall pulses; a change counts once stages two and three agree.
module edge_sync
(
    input wire clk_sys,
    input wire srst,
    input wire pin_in,
    output reg level_r,
    output wire rise,
    output wire fall
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // The first stage feeds only the second, so no logic sees a metastable value.
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
            begin
                level_r <= s3_r;
            end
        end
    end

    // Edges are taken against the filtered level.
    assign rise = (s2_r == s3_r) && s3_r && !level_r;
    assign fall = (s2_r == s3_r) && !s3_r && level_r;
endmodule // edge_sync
`default_nettype wire

// >>> logic/trim_scaler.v
`timescale 1ns/100ps
`default_nettype none
`include "trim_status_defs.vh"
// Turns one trim code into a fraction of full-scale current, code/127 in CURRENT_W bits.
module trim_scaler
(
    input wire clk_sys,
    input wire [6:0] code,
    output reg [15:0] fraction_r
);
    // Scale code*65535/127 so that the maximum code gives exactly full scale.
    function [15:0] scale;
        input [6:0] c;
        reg [22:0] prod;
        reg [22:0] quot;
        begin
            prod = {16'h0000, c} * 23'hffff;
            quot = prod / 23'h7f;
            // The quotient never exceeds 65535, so the upper bits are dropped on purpose.
            scale = quot[15:0];
        end
    endfunction

    // Registered so the top-level output comes straight from a flip-flop.
    always @(posedge clk_sys)
    begin
        fraction_r <= scale(code);
    end
endmodule // trim_scaler
`default_nettype wire

// >>> logic/trim_status_core.v
// Functional notes
// - Load status word after strobe low, first shift edge.
// - Open-LED bits saved at previous period's 33rd edge.
// - Over-temperature sampled at that same shift edge.
// - Separate trim setting for sixteen outputs.
// - Trim gives 128 steps, zero to full.
// - Current equals full scale times code/127.
// - Code 127 gives full-scale current.
// - No reset default for trim registers.
// - 112-bit trim chain, MSB first, rising edges.
// - Trim strobe rising edge copies shift to latch.
// - 17 status bits overwrite top; rest untouched.
// - Serial output shifts on each shift-clock rise.
`timescale 1ns/100ps
`default_nettype none
`include "trim_status_defs.vh"
module trim_status_core
#(
    parameter CHANNELS = `CHAN_COUNT
)
(
    input wire clk_sys,
    input wire srst,
    // AHB-Lite slave.
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Trim serial port.
    input wire trim_serial_in,
    input wire trim_shift_clock,
    input wire trim_latch_strobe,
    // Grayscale shift port.
    input wire grayscale_serial_in,
    input wire grayscale_shift_clock,
    input wire grayscale_latch_strobe,
    input wire grayscale_ref_clock,
    output reg grayscale_serial_out,
    // Analog-side inputs.
    input wire [15:0] open_led_flag,
    input wire overtemp_flag,
    // Per-channel current fractions, 16 bits each, channel 0 lowest.
    output wire [16*CHANNELS-1:0] channel_current,
    output reg irq
);
    // Synchronised pin levels and edges.
    wire tclk_rise;
    wire tlat_rise;
    wire tdin;
    wire gclk_rise;
    wire glat_rise;
    wire glat_fall;
    wire gdin;
    wire rclk_rise;
    wire otemp;
    wire [15:0] open_sync;

    // Every pin passes its own synchroniser, so data and clock pins see the same delay and stay in step.
    edge_sync u_tclk
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(trim_shift_clock),
        .level_r(),
        .rise(tclk_rise),
        .fall()
    );
    edge_sync u_tlat
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(trim_latch_strobe),
        .level_r(),
        .rise(tlat_rise),
        .fall()
    );
    edge_sync u_tdin
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(trim_serial_in),
        .level_r(tdin),
        .rise(),
        .fall()
    );
    edge_sync u_gclk
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(grayscale_shift_clock),
        .level_r(),
        .rise(gclk_rise),
        .fall()
    );
    edge_sync u_glat
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(grayscale_latch_strobe),
        .level_r(),
        .rise(glat_rise),
        .fall(glat_fall)
    );
    edge_sync u_gdin
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(grayscale_serial_in),
        .level_r(gdin),
        .rise(),
        .fall()
    );
    edge_sync u_rclk
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(grayscale_ref_clock),
        .level_r(),
        .rise(rclk_rise),
        .fall()
    );
    edge_sync u_otmp
    (
        .clk_sys(clk_sys),
        .srst(srst),
        .pin_in(overtemp_flag),
        .level_r(otemp),
        .rise(),
        .fall()
    );

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1)
        begin : g_open
            edge_sync u_open
            (
                .clk_sys(clk_sys),
                .srst(srst),
                .pin_in(open_led_flag[gi]),
                .level_r(open_sync[gi]),
                .rise(),
                .fall()
            );
        end
    endgenerate

    // Trim shift chain and latch have no reset: contents stay undefined until written.
    reg [`TRIM_CHAIN_W-1:0] trim_shift_r;
    reg [`TRIM_CHAIN_W-1:0] trim_latch_r;
    wire sw_latch;

    // Serial data enters at bit 0 so the first bit ends at the top, MSB first.
    always @(posedge clk_sys)
    begin
        if (tclk_rise)
        begin
            trim_shift_r <= {trim_shift_r[`TRIM_CHAIN_W-2:0], tdin};
        end
        if (tlat_rise || sw_latch)
        begin
            trim_latch_r <= trim_shift_r;
        end
    end

    // One scaler per channel, each reading its own slice of the latch.
    generate
        for (gi = 0; gi < CHANNELS; gi = gi + 1)
        begin : g_ch
            wire [15:0] frac;
            trim_scaler u_scale (.clk_sys(clk_sys), .code(trim_latch_r[7*gi+6:7*gi]), .fraction_r(frac));
            assign channel_current[16*gi+15:16*gi] = frac;
        end
    endgenerate

    // Grayscale chain, status capture and the per-period edge count.
    reg [`GS_CHAIN_W-1:0] gs_shift_r;
    reg capture_pend_r;
    reg [15:0] open_saved_r;
    reg [`GS_EDGE_CNT_W-1:0] period_cnt_r;
    reg otemp_seen_r;
    reg status_loaded_r;

    // The 33rd reference edge of a period saves open-LED results for the next readout.
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            period_cnt_r <= {`GS_EDGE_CNT_W{1'b0}};
            open_saved_r <= 16'h0000;
        end
        else
        begin
            if (glat_rise)
            begin
                period_cnt_r <= {`GS_EDGE_CNT_W{1'b0}};
            end
            else if (rclk_rise && period_cnt_r != {`GS_EDGE_CNT_W{1'b1}})
            begin
                period_cnt_r <= period_cnt_r + 1'b1;
                if (period_cnt_r == `OPEN_SAVE_EDGE - 1)
                begin
                    open_saved_r <= open_sync;
                end
            end
        end
    end

    // Status load wins over shifting on the first shift edge after the strobe falls.
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            capture_pend_r <= 1'b0;
            status_loaded_r <= 1'b0;
            otemp_seen_r <= 1'b0;
            grayscale_serial_out <= 1'b0;
        end
        else
        begin
            status_loaded_r <= 1'b0;
            otemp_seen_r <= 1'b0;
            if (glat_fall)
            begin
                capture_pend_r <= 1'b1;
            end
            if (gclk_rise)
            begin
                if (capture_pend_r)
                begin
                    gs_shift_r[`GS_CHAIN_W-1 -: `STATUS_W] <= {otemp, open_saved_r};
                    capture_pend_r <= 1'b0;
                    status_loaded_r <= 1'b1;
                    otemp_seen_r <= otemp;
                    grayscale_serial_out <= otemp;
                end
                else
                begin
                    gs_shift_r <= {gs_shift_r[`GS_CHAIN_W-2:0], gdin};
                    grayscale_serial_out <= gs_shift_r[`GS_CHAIN_W-2];
                end
            end
        end
    end

    // AHB-Lite slave: one-cycle address capture, zero wait states, always OKAY.
    reg wr_pend_r;
    reg [11:0] addr_r;
    reg [`IRQ_W-1:0] irq_stat_r;
    reg [`IRQ_W-1:0] irq_mask_r;
    reg [11:0] rd_addr;
    wire take = hsel && hready && htrans[1];
    wire wr_now = wr_pend_r;
    wire [`IRQ_W-1:0] events = {otemp_seen_r, status_loaded_r, tlat_rise};
    wire [`IRQ_W-1:0] clr = (wr_now && addr_r == `REG_IRQ_STAT) ? hwdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
    assign sw_latch = wr_now && addr_r == `REG_CTRL && hwdata[0];

    // Decodes one register for reads; the trim window shows latched codes.
    function [31:0] read_reg;
        input [11:0] a;
        begin
            read_reg = 32'h00000000;
            if (a == `REG_CTRL)
                read_reg = {31'h0, capture_pend_r};
            else if (a == `REG_STATUS)
                read_reg = {15'h0, otemp, open_saved_r};
            else if (a == `REG_IRQ_STAT)
                read_reg = {29'h0, irq_stat_r};
            else if (a == `REG_IRQ_MASK)
                read_reg = {29'h0, irq_mask_r};
            else if (a >= `REG_TRIM_BASE && a < `REG_TRIM_BASE + 12'h040)
                read_reg = {25'h0, trim_latch_r[7*(a[5:2])+:7]};
        end
    endfunction

    always @*
    begin
        rd_addr = haddr;
    end

    // Event set wins over a write-one clear in the same cycle.
    always @(posedge clk_sys)
    begin
        if (srst)
        begin
            wr_pend_r <= 1'b0;
            addr_r <= 12'h000;
            irq_stat_r <= {`IRQ_W{1'b0}};
            irq_mask_r <= {`IRQ_W{1'b0}};
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            wr_pend_r <= take && hwrite;
            if (take)
            begin
                addr_r <= {haddr[11:2], 2'b00};
            end
            if (take && !hwrite)
            begin
                hrdata <= read_reg({rd_addr[11:2], 2'b00});
            end
            if (wr_now && addr_r == `REG_IRQ_MASK)
            begin
                irq_mask_r <= hwdata[`IRQ_W-1:0];
            end
            irq_stat_r <= (irq_stat_r & ~clr) | events;
            irq <= |(((irq_stat_r & ~clr) | events) & irq_mask_r);
        end
    end
endmodule // trim_status_core
`default_nettype wire

// >>> sim/trim_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module trim_host_model
(
    output logic trim_serial_in,
    output logic trim_shift_clock,
    output logic trim_latch_strobe,
    output logic grayscale_serial_in,
    output logic grayscale_shift_clock,
    output logic grayscale_latch_strobe,
    output logic grayscale_ref_clock
);
    // Clocks and strobes stand low between frames.
    initial
    begin
        {trim_serial_in, trim_shift_clock, trim_latch_strobe, grayscale_serial_in} = 4'h0;
        {grayscale_shift_clock, grayscale_latch_strobe, grayscale_ref_clock} = 3'h0;
    end
    // The odd 7 ns offset keeps pin edges off the system clock edges.
    task send_trim(input logic [111:0] d, input logic latch);
        #7;
        for (int i = 111; i >= 0; i--)
        begin
            trim_serial_in = d[i];
            #100 trim_shift_clock = 1'b1;
            #100 trim_shift_clock = 1'b0;
        end
        trim_serial_in = ~d[0];
        #100 trim_latch_strobe = latch;
        #100 trim_latch_strobe = 1'b0;
    endtask
    // Pulses the shift clock, or the reference clock when sel is set, with data in runs of sixteen.
    // Each pulse lasts nine system cycles, so pin edges never drift onto a system clock edge.
    task pulse_gs(input int n, input logic sel);
        for (int i = 0; i < n; i++)
        begin
            #7 grayscale_serial_in = i[4];
            #100 {grayscale_ref_clock, grayscale_shift_clock} = {sel, !sel};
            #100 {grayscale_ref_clock, grayscale_shift_clock} = 2'h0;
            grayscale_serial_in = 1'b0;
            #18;
        end
    endtask
    task gs_strobe(input logic v);
        #107 grayscale_latch_strobe = v;
        #100;
    endtask
endmodule // trim_host_model
`default_nettype wire

// >>> sim/trim_status_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module trim_status_core_monitor
#(
    parameter CHANNELS = 16
)
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic trim_latch_strobe,
    input wire logic grayscale_shift_clock,
    input wire logic grayscale_latch_strobe,
    input wire logic grayscale_serial_out,
    input wire logic overtemp_flag,
    input wire logic [16*CHANNELS-1:0] channel_current
);
    logic lat_r, gsc_r, gsl_r, arm_r;
    logic [3:0] lat_cnt_r, gs_cnt_r;
    wire logic rd = htrans[1] && !hwrite;
    wire logic gs_rise = grayscale_shift_clock && !gsc_r;
    // Ages since the last latch request or shift edge; an output moving long after one had no cause.
    always @(posedge clk_sys)
    begin
        lat_r <= trim_latch_strobe;
        gsc_r <= grayscale_shift_clock;
        gsl_r <= grayscale_latch_strobe;
        lat_cnt_r <= (srst || (trim_latch_strobe && !lat_r) || (htrans[1] && hwrite && haddr == 12'h000)) ? 4'h0
            : lat_cnt_r + {3'h0, lat_cnt_r != 4'hf};
        gs_cnt_r <= (srst || gs_rise) ? 4'h0 : gs_cnt_r + {3'h0, gs_cnt_r != 4'hf};
        arm_r <= !srst && (arm_r ? !gs_rise : gsl_r && !grayscale_latch_strobe);
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    a_ready_high: assert property (hreadyout) else $error("wait state inserted");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_unmapped_zero: assert property (rd && haddr >= 12'h080 |=> hrdata == 32'h0) else $error("unmapped read");
    a_trim_first: assert property (rd && haddr == 12'h040 |=>
        {16'h0, channel_current[15:0]} == {25'h0, hrdata[6:0]} * 32'd65535 / 32'd127)
        else $error("channel 0 current");
    a_trim_last: assert property (rd && haddr == 12'h07c |=>
        {16'h0, channel_current[16*CHANNELS-1 -: 16]} == {25'h0, hrdata[6:0]} * 32'd65535 / 32'd127)
        else $error("channel 15 current");
    a_latch_cause: assert property ($changed(channel_current) |-> lat_cnt_r < 4'ha)
        else $error("current changed without latch");
    a_shift_cause: assert property ($changed(grayscale_serial_out) |-> gs_cnt_r < 4'h7)
        else $error("output moved without shift edge");
    a_load_tef: assert property (arm_r && gs_rise |-> ##[2:8] grayscale_serial_out == overtemp_flag)
        else $error("status load missing");
endmodule // trim_status_core_monitor
bind trim_status_core trim_status_core_monitor #(.CHANNELS(CHANNELS)) i_trim_status_core_monitor (.clk_sys, .srst,
    .haddr, .htrans, .hwrite, .hrdata, .hreadyout, .hresp, .trim_latch_strobe, .grayscale_shift_clock,
    .grayscale_latch_strobe, .grayscale_serial_out, .overtemp_flag, .channel_current);
`default_nettype wire

// >>> sim/dot_correction_status_capture_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dot_correction_status_capture_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic overtemp_flag = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [11:0] haddr = 12'h000;
    logic [15:0] open_led_flag = 16'h0000;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rd;
    logic [111:0] word;
    logic [16:0] status_exp = 17'h1c3a6;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    wire logic hreadyout, hresp, irq, trim_serial_in, trim_shift_clock, trim_latch_strobe, grayscale_serial_in;
    wire logic grayscale_shift_clock, grayscale_latch_strobe, grayscale_ref_clock, grayscale_serial_out;
    wire logic [31:0] hrdata;
    wire logic [255:0] channel_current;
    trim_status_core i_trim_status_core (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .trim_serial_in, .trim_shift_clock, .trim_latch_strobe,
        .grayscale_serial_in, .grayscale_shift_clock, .grayscale_latch_strobe, .grayscale_ref_clock,
        .grayscale_serial_out, .open_led_flag, .overtemp_flag, .channel_current, .irq);
    trim_host_model i_trim_host_model (.trim_serial_in, .trim_shift_clock, .trim_latch_strobe, .grayscale_serial_in,
        .grayscale_shift_clock, .grayscale_latch_strobe, .grayscale_ref_clock);
    // Free-running system clock.
    always #12.5 clk_sys = ~clk_sys;
    // The run needs about 4400 cycles, so this limit only trips on a hang.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            close_out;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One single AHB transfer; each phase holds until hready is seen high.
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, a};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        {hsel, htrans} <= 3'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask
    function automatic logic [6:0] code_of(input logic q, input int n);
        code_of = q ? 7'(127 - n * 5) : ((n == 15) ? 7'h7f : 7'(n * 9));
    endfunction
    // Pin latch, then a shifted word held back until the bus command latches it.
    task trim_test;
        for (int p = 0; p < 3; p++)
        begin
            for (int n = 0; n < 16; n++)
                word[7 * n +: 7] = code_of(p != 0, n);
            if (p < 2)
                i_trim_host_model.send_trim(word, p == 0);
            else
                bus(1'b1, 12'h000, 32'h1);
            repeat (12) @(posedge clk_sys);
            for (int n = 0; n < 16; n++)
            begin
                bus(1'b0, 12'h040 + 12'(4 * n), 32'h0);
                chk(rd, {25'h0, code_of(p == 2, n)});
                chk({16'h0, channel_current[16 * n +: 16]}, code_of(p == 2, n) * 32'd65535 / 32'd127);
            end
        end
    endtask
    // Only the open pattern at the 33rd reference edge may be saved.
    task status_test;
        i_trim_host_model.pulse_gs(192, 1'b0);
        i_trim_host_model.gs_strobe(1'b1);
        i_trim_host_model.pulse_gs(32, 1'b1);
        @(posedge clk_sys);
        open_led_flag <= status_exp[15:0];
        i_trim_host_model.pulse_gs(1, 1'b1);
        @(posedge clk_sys);
        {overtemp_flag, open_led_flag} <= {1'b1, ~status_exp[15:0]};
        i_trim_host_model.pulse_gs(2, 1'b1);
        i_trim_host_model.gs_strobe(1'b0);
        bus(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h1);
        for (int i = 16; i >= -1; i--)
        begin
            i_trim_host_model.pulse_gs(1, 1'b0);
            repeat (6) @(posedge clk_sys);
            chk({31'h0, grayscale_serial_out}, {31'h0, (i < 0) ? 1'b1 : status_exp[i]});
        end
        bus(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 12'h004, 32'h0);
        chk(rd, {15'h0, status_exp});
    endtask
    task irq_test;
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 12'h00c, 32'h7);
        bus(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h7);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 12'h008, 32'h5);
        bus(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h2);
        bus(1'b1, 12'h00c, 32'h5);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 12'h100, 32'hffffffff);
        bus(1'b0, 12'h100, 32'h0);
        chk(rd, 32'h0);
    endtask
    task close_out;
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Reset for two cycles, then each scenario in turn.
    initial
    begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        trim_test;
        status_test;
        irq_test;
        close_out;
    end
endmodule // dot_correction_status_capture_tb
`default_nettype wire
